// ==== testbench/irfc_optics_model.sv ====
/*
   Behavioural infrared optics that drive both receive pins of the set.
   Assumes the bench gives the light level seen by each receiver.
*/
`timescale 1ns/10ps
module irfc_optics_model (
   input  wire logic clock,
   input  wire logic ir_level,
   input  wire logic alt_level,
   output logic      ir_receive_pin,
   output logic      alt_receive_pin
);
   initial begin
      ir_receive_pin = 1'b0;
      alt_receive_pin = 1'b0;
   end
   // Pins are asynchronous; a small skew keeps them off the sampling edge
   always @(posedge clock) begin
      ir_receive_pin <= #1 ir_level;
      alt_receive_pin <= #1 alt_level;
   end
endmodule

// ==== testbench/testbench.sv ====
/*
   Self-checking bench of the flow control and frame status register set.
   Assumes irfc_set5, its package and the optics model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
   logic                  clock = 1'b0;
   logic                  rst_n = 1'b0;
   logic [2:0]            reg_addr = 3'h0;
   logic [7:0]            reg_wdata = 8'h00;
   logic                  reg_wr = 1'b0;
   logic                  reg_rd = 1'b0;
   logic [5:0]            ev_bus = 6'h00;
   irfc_pkg::irfc_entry_s status_entry = '0;
   logic [7:0]            hs_status_in = 8'h00;
   logic                  ir_level = 1'b0;
   logic                  alt_level = 1'b0;
   logic                  ir_pin, alt_pin, dl_ld, ml_ld, dma_act, dma_tx;
   logic                  irq, split, fdx, rx_allow, rx_in;
   logic [7:0]            reg_rdata, set_sel, hs_reg, lo, hi;
   logic [15:0]           adv_div;
   logic [2:0]            adv_mode;
   logic [7:0]            rq[$];
   irfc_pkg::irfc_entry_s em[$];
   irfc_pkg::irfc_entry_s e;
   logic                  rd_d = 1'b0;
   logic [31:0]           seed = 32'h0001_2a1b;
   logic [7:0]            v;
   logic [7:0]            fcv [3] = '{8'h0d, 8'h05, 8'h0c};
   int                    num_errors = 0;
   int                    comparisons = 0;

   always #2 clock = ~clock;

   irfc_optics_model optics (.clock(clock), .ir_level(ir_level), .alt_level(alt_level),
      .ir_receive_pin(ir_pin), .alt_receive_pin(alt_pin));

   irfc_set5 dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_to_sir(ev_bus[5]),
      .status_push(ev_bus[4]), .status_entry(status_entry), .frame_lost(ev_bus[3]),
      .rx_fifo_overrun(ev_bus[2]), .length_exceeded(ev_bus[1]), .frame_start(ev_bus[0]),
      .hs_status_in(hs_status_in), .ir_receive_pin(ir_pin), .alt_receive_pin(alt_pin),
      .set_select(set_sel), .advanced_divisor(adv_div), .advanced_divisor_load(dl_ld),
      .advanced_handshake_mode(adv_mode), .advanced_mode_load(ml_ld),
      .flow_dma_active(dma_act), .dma_tx_channel(dma_tx), .status_fifo_interrupt(irq),
      .auto_frame_split(split), .full_duplex_select(fdx), .rx_write_allow(rx_allow),
      .handshake_status_reg(hs_reg), .rx_data_in(rx_in));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic void chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endfunction

   // Read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      if (rd_d) chk(16'(reg_rdata), 16'(rq.pop_front()));
      rd_d <= reg_rd;
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(exp);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask

   task automatic ev(input logic [5:0] m);
      @(posedge clock);
      ev_bus <= m;
      @(posedge clock);
      ev_bus <= 6'h00;
   endtask

   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask

   // Pulse the mode change and look at the load strobes the cycle after
   task automatic sir(input logic exp_dl, input logic exp_ml);
      ev(6'h20);
      #1;
      chk(16'(dl_ld), 16'(exp_dl));
      chk(16'(ml_ld), 16'(exp_ml));
      @(posedge clock);
      #1;
      chk(16'({dl_ld, ml_ld}), 16'h0000);
   endtask

   // Dropped entries stay out of the model queue
   task automatic push;
      seed = lfsr(seed);
      e = seed[15:0];
      @(posedge clock);
      status_entry <= e;
      ev_bus <= 6'h10;
      @(posedge clock);
      ev_bus <= 6'h00;
      if (em.size() < 8) em.push_back(e);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole run is about two hundred cycles; generous margin
   initial begin
      #(5000 * 4);
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rd(3'h2, 8'h00);
      rd(3'h3, 8'hec);
      rd(3'h4, 8'h00);
      rd(3'h5, 8'h00);
      #1;
      chk(16'(set_sel), 16'h00ec);
      wr(3'h3, 8'h05);
      rd(3'h3, 8'hec);
      settle();
      chk(16'(set_sel), 16'h0005);
      done("reset and set select");
      seed = lfsr(seed);
      lo = seed[7:0];
      hi = seed[15:8];
      wr(3'h0, lo);
      wr(3'h1, hi);
      wr(3'h2, 8'ha3);
      sir(1'b1, 1'b1);
      chk(adv_div, {hi, lo});
      chk(16'(adv_mode), 16'h0005);
      wr(3'h2, 8'h41);
      sir(1'b0, 1'b1);
      chk(16'(adv_mode), 16'h0002);
      wr(3'h2, 8'hee);
      sir(1'b0, 1'b0);
      wr(3'h2, 8'hff);
      rd(3'h2, 8'hef);
      for (int i = 0; i < 3; i++) begin
         v = fcv[i];
         wr(3'h2, v);
         settle();
         chk(16'(dma_act), 16'(v[0] & v[2]));
         chk(16'(dma_tx), 16'(v[0] & v[3]));
      end
      done("flow control");
      wr(3'h4, 8'hff);
      rd(3'h4, 8'h73);
      ir_level <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      chk(16'({split, fdx}), 16'h0003);
      chk(16'(hs_reg), 16'h0030);
      chk(16'(rx_in), 16'h0001);
      seed = lfsr(seed);
      wr(3'h4, 8'h00);
      hs_status_in <= seed[23:16];
      repeat (8) @(posedge clock);
      #1;
      chk(16'({split, fdx}), 16'h0000);
      chk(16'(hs_reg), 16'(seed[23:16]));
      chk(16'(rx_in), 16'h0000);
      done("infrared config");
      push();
      settle();
      chk(16'(irq), 16'h0000);
      push();
      settle();
      chk(16'(irq), 16'h0001);
      wr(3'h4, 8'h40);
      settle();
      chk(16'(irq), 16'h0000);
      repeat (2) push();
      settle();
      chk(16'(irq), 16'h0001);
      repeat (5) push();
      for (int i = 0; i < 8; i++) begin
         e = em.pop_front();
         rd(3'h5, {2'b10, 1'b0, e.lex, e.phy, e.crc, 1'b0, i == 0});
         rd(3'h6, e.len[7:0]);
         rd(3'h7, {3'b000, e.len[12:8]});
      end
      rd(3'h5, 8'h00);
      done("status fifo");
      repeat (3) ev(6'h08);
      ev(6'h04);
      rd(3'h6, 8'h03);
      rd(3'h5, 8'h42);
      rd(3'h5, 8'h00);
      rd(3'h6, 8'h00);
      ev(6'h02);
      settle();
      chk(16'(rx_allow), 16'h0000);
      ev(6'h01);
      settle();
      chk(16'(rx_allow), 16'h0001);
      done("lost frames and overrun");
      repeat (4) @(posedge clock);
      print_verdict();
   end
endmodule

// ==== verilog/irfc_consts.svh ====
/*
   Offsets, field positions, reset values and counts of the flow control and
   frame status register set. Assumes a 3-bit register offset and 8-bit data.
*/
`ifndef IRFC_CONSTS_SVH
`define IRFC_CONSTS_SVH

`define IRFC_OFF_DIV_LO    3'h0
`define IRFC_OFF_DIV_HI    3'h1
`define IRFC_OFF_FC_MODE   3'h2
`define IRFC_OFF_SET_SEL   3'h3
`define IRFC_OFF_CFG       3'h4
`define IRFC_OFF_STATUS    3'h5
`define IRFC_OFF_LEN_LO    3'h6
`define IRFC_OFF_LEN_HI    3'h7

`define IRFC_FCM_MODE_MSB  7
`define IRFC_FCM_MODE_LSB  5
`define IRFC_FCM_DSW       3
`define IRFC_FCM_FD        2
`define IRFC_FCM_BRFC      1
`define IRFC_FCM_EN        0
`define IRFC_FCM_MASK      8'hef

`define IRFC_CFG_TH        6
`define IRFC_CFG_SPLIT     5
`define IRFC_CFG_AUX       4
`define IRFC_CFG_HSSL      1
`define IRFC_CFG_FULL      0
`define IRFC_CFG_MASK      8'h73

`define IRFC_FC_MODE_RST   8'h00
`define IRFC_CFG_RST       8'h00
`define IRFC_SET_SEL_RST   8'hec
`define IRFC_SET_SEL_READ  8'hec
`define IRFC_HS_DISABLED   8'h30

`define IRFC_THRESH_LO     4'h2
`define IRFC_THRESH_HI     4'h4
`define IRFC_FIFO_FULL     4'h8
`define IRFC_LOST_MAX      8'hff

`endif

// ==== verilog/irfc_pkg.sv ====
/*
   Types of the flow control and frame status register set.
   Assumes irfc_consts.svh supplies all numeric constants.
*/
package irfc_pkg;

   typedef struct packed {
      logic        lex;
      logic        phy;
      logic        crc;
      logic [12:0] len;
   } irfc_entry_s;

   typedef struct packed {
      logic [7:0]           div_lo;
      logic [7:0]           div_hi;
      logic [7:0]           fc_mode;
      logic [7:0]           cfg;
      logic [7:0]           set_sel;
      irfc_entry_s [7:0]    mem;
      logic [2:0]           wr_ptr;
      logic [2:0]           rd_ptr;
      logic [3:0]           count;
      logic                 lost_flag;
      logic [7:0]           lost_cnt;
      logic                 rx_ovf;
      logic                 stat_ovf;
      logic [7:0]           rdata;
      logic [15:0]          adv_div;
      logic                 adv_div_load;
      logic [2:0]           adv_mode;
      logic                 adv_mode_load;
      logic                 dma_use;
      logic                 dma_tx;
      logic                 fsf_irq;
      logic                 auto_split;
      logic                 full_dx;
      logic                 rx_allow;
      logic [7:0]           hs_view;
      logic [2:0]           pin_sync;
      logic [2:0]           alt_sync;
      logic                 pin_filt;
      logic                 alt_filt;
      logic                 rx_in;
   } irfc_state_s;

endpackage

// ==== verilog/irfc_set5.sv ====
/*
   Flow control, infrared configuration and receive frame status FIFO set.
   Assumes a single 250 MHz clock, a one-cycle strobe register port, and
   receive events as one-cycle pulses from logic on the same clock.
*/
`timescale 1ns/10ps
`include "irfc_consts.svh"

// Operation
// - With flow control on and reload on, SIR switch copies divisor pair to advanced latch.
// - With flow control on, SIR switch copies mode bits 7..5 to advanced handshake mode.
// - Swap bit picks DMA direction after flow control: 0 receiver, 1 transmitter.
// - Flow DMA enable bit lets the UART use DMA under flow control.
// - Reload enable bit permits divisor reload; without it no reload happens.
// - Bit 0 enables flow control; bits 7..1 act only while it is set.
// - Write offset 3 selects set; reading offset 3 returns ECH.
// - Threshold bit picks status interrupt level: 0 gives 2, 1 gives 4.
// - Frame end mode bit enables automatic equal-length transmit frame splitting.
// - Auxiliary receive bit routes receiver input from the infrared receive pin.
// - Handshake select 1 disables handshake status, which then reads 30H.
// - Duplex bit: 0 half duplex, 1 full duplex.
// - Offset 5 read shows the oldest status FIFO entry.
// - Ready bit 7 is 1 while a valid entry sits at the FIFO bottom.
// - Lost bit 6 set once one or more frames were lost.
// - Length exceeded bit 4 of bottom entry, valid only when ready.
// - Physical error bit 3 of bottom entry, valid only when ready.
// - CRC error bit 2 of bottom entry, valid only when ready.
// - Receive overrun bit 1 set when receiver data FIFO overruns.
// - Status FIFO overrun bit 0 set when the status FIFO overruns.
// - Reading offset 7 pops the next status entry when ready.
// - While lost bit is 1, offset 6 reads the 8-bit lost frame count.
// - After length exceeded, receive writes stop until next frame start flag.
module irfc_set5 (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [2:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  mode_to_sir,
   input  wire logic                  status_push,
   input  wire irfc_pkg::irfc_entry_s status_entry,
   input  wire logic                  frame_lost,
   input  wire logic                  rx_fifo_overrun,
   input  wire logic                  length_exceeded,
   input  wire logic                  frame_start,
   input  wire logic [7:0]            hs_status_in,
   input  wire logic                  ir_receive_pin,
   input  wire logic                  alt_receive_pin,
   output logic      [7:0]            set_select,
   output logic      [15:0]           advanced_divisor,
   output logic                       advanced_divisor_load,
   output logic      [2:0]            advanced_handshake_mode,
   output logic                       advanced_mode_load,
   output logic                       flow_dma_active,
   output logic                       dma_tx_channel,
   output logic                       status_fifo_interrupt,
   output logic                       auto_frame_split,
   output logic                       full_duplex_select,
   output logic                       rx_write_allow,
   output logic      [7:0]            handshake_status_reg,
   output logic                       rx_data_in
);

   irfc_pkg::irfc_state_s st_ff;
   irfc_pkg::irfc_state_s nxt_st;

   logic                  wr_hit [8];
   logic                  pop;
   logic                  push_ok;
   logic                  fc_on;
   logic                  ready;
   irfc_pkg::irfc_entry_s bottom;

   // Three-stage sync; stage one is never looked at directly
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   function automatic logic [3:0] thresh(input logic sel);
      thresh = sel ? `IRFC_THRESH_HI : `IRFC_THRESH_LO;
   endfunction

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         wr_hit[i] = reg_wr && (reg_addr == 3'(i));
      end
      fc_on   = st_ff.fc_mode[`IRFC_FCM_EN];
      ready   = (st_ff.count != 4'h0);
      bottom  = st_ff.mem[st_ff.rd_ptr];
      pop     = reg_rd && (reg_addr == `IRFC_OFF_LEN_HI) && ready;
      push_ok = status_push && ((st_ff.count != `IRFC_FIFO_FULL) || pop);
   end

   always_comb begin
      nxt_st = st_ff;

      if (wr_hit[`IRFC_OFF_DIV_LO]) begin
         nxt_st.div_lo = reg_wdata;
      end
      if (wr_hit[`IRFC_OFF_DIV_HI]) begin
         nxt_st.div_hi = reg_wdata;
      end
      if (wr_hit[`IRFC_OFF_FC_MODE]) begin
         nxt_st.fc_mode = reg_wdata & `IRFC_FCM_MASK;
      end
      if (wr_hit[`IRFC_OFF_SET_SEL]) begin
         nxt_st.set_sel = reg_wdata;
      end
      if (wr_hit[`IRFC_OFF_CFG]) begin
         nxt_st.cfg = reg_wdata & `IRFC_CFG_MASK;
      end

      // Reload only on the mode switch itself, so software can preload freely
      nxt_st.adv_div_load  = 1'b0;
      nxt_st.adv_mode_load = 1'b0;
      if (mode_to_sir && fc_on && st_ff.fc_mode[`IRFC_FCM_BRFC]) begin
         nxt_st.adv_div      = {st_ff.div_hi, st_ff.div_lo};
         nxt_st.adv_div_load = 1'b1;
      end
      if (mode_to_sir && fc_on) begin
         nxt_st.adv_mode      = st_ff.fc_mode[`IRFC_FCM_MODE_MSB:`IRFC_FCM_MODE_LSB];
         nxt_st.adv_mode_load = 1'b1;
      end
      nxt_st.dma_use = fc_on && st_ff.fc_mode[`IRFC_FCM_FD];
      nxt_st.dma_tx  = fc_on && st_ff.fc_mode[`IRFC_FCM_DSW];

      nxt_st.auto_split = st_ff.cfg[`IRFC_CFG_SPLIT];
      nxt_st.full_dx    = st_ff.cfg[`IRFC_CFG_FULL];
      nxt_st.hs_view    = st_ff.cfg[`IRFC_CFG_HSSL] ? `IRFC_HS_DISABLED : hs_status_in;
      nxt_st.fsf_irq    = (st_ff.count >= thresh(st_ff.cfg[`IRFC_CFG_TH]));

      nxt_st.pin_sync = {st_ff.pin_sync[1:0], ir_receive_pin};
      nxt_st.alt_sync = {st_ff.alt_sync[1:0], alt_receive_pin};
      nxt_st.pin_filt = filt(st_ff.pin_sync, st_ff.pin_filt);
      nxt_st.alt_filt = filt(st_ff.alt_sync, st_ff.alt_filt);
      nxt_st.rx_in    = st_ff.cfg[`IRFC_CFG_AUX] ? st_ff.pin_filt : st_ff.alt_filt;

      // A new start flag outranks the stop of the frame before it
      if (frame_start) begin
         nxt_st.rx_allow = 1'b1;
      end else if (length_exceeded) begin
         nxt_st.rx_allow = 1'b0;
      end

      // Status FIFO; a push into a full FIFO leaves the stored entries alone
      if (push_ok) begin
         nxt_st.mem[st_ff.wr_ptr] = status_entry;
         nxt_st.wr_ptr            = st_ff.wr_ptr + 3'h1;
      end
      if (pop) begin
         nxt_st.rd_ptr = st_ff.rd_ptr + 3'h1;
      end
      nxt_st.count = st_ff.count + {3'h0, push_ok} - {3'h0, pop};

      // Sticky flags clear on a status read; an event in that cycle still lands
      if (reg_rd && (reg_addr == `IRFC_OFF_STATUS)) begin
         nxt_st.lost_flag = 1'b0;
         nxt_st.lost_cnt  = 8'h00;
         nxt_st.rx_ovf    = 1'b0;
         nxt_st.stat_ovf  = 1'b0;
      end
      if (frame_lost) begin
         nxt_st.lost_flag = 1'b1;
         nxt_st.lost_cnt  = (st_ff.lost_cnt == `IRFC_LOST_MAX) ? st_ff.lost_cnt
                                                               : st_ff.lost_cnt + 8'h01;
         if (reg_rd && (reg_addr == `IRFC_OFF_STATUS)) begin
            nxt_st.lost_cnt = 8'h01;
         end
      end
      if (rx_fifo_overrun) begin
         nxt_st.rx_ovf = 1'b1;
      end
      if (status_push && !push_ok) begin
         nxt_st.stat_ovf = 1'b1;
      end

      // Read data stand one cycle only
      nxt_st.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `IRFC_OFF_DIV_LO:  nxt_st.rdata = st_ff.div_lo;
            `IRFC_OFF_DIV_HI:  nxt_st.rdata = st_ff.div_hi;
            `IRFC_OFF_FC_MODE: nxt_st.rdata = st_ff.fc_mode;
            `IRFC_OFF_SET_SEL: nxt_st.rdata = `IRFC_SET_SEL_READ;
            `IRFC_OFF_CFG:     nxt_st.rdata = st_ff.cfg;
            `IRFC_OFF_STATUS: begin
               nxt_st.rdata[7] = ready;
               nxt_st.rdata[6] = st_ff.lost_flag;
               nxt_st.rdata[4] = ready && bottom.lex;
               nxt_st.rdata[3] = ready && bottom.phy;
               nxt_st.rdata[2] = ready && bottom.crc;
               nxt_st.rdata[1] = st_ff.rx_ovf;
               nxt_st.rdata[0] = st_ff.stat_ovf;
            end
            `IRFC_OFF_LEN_LO: begin
               if (st_ff.lost_flag) begin
                  nxt_st.rdata = st_ff.lost_cnt;
               end else if (ready) begin
                  nxt_st.rdata = bottom.len[7:0];
               end
            end
            `IRFC_OFF_LEN_HI: begin
               if (ready) begin
                  nxt_st.rdata = {3'h0, bottom.len[12:8]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff          <= '0;
         st_ff.fc_mode  <= `IRFC_FC_MODE_RST;
         st_ff.cfg      <= `IRFC_CFG_RST;
         st_ff.set_sel  <= `IRFC_SET_SEL_RST;
         st_ff.rx_allow <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata               = st_ff.rdata;
   assign set_select              = st_ff.set_sel;
   assign advanced_divisor        = st_ff.adv_div;
   assign advanced_divisor_load   = st_ff.adv_div_load;
   assign advanced_handshake_mode = st_ff.adv_mode;
   assign advanced_mode_load      = st_ff.adv_mode_load;
   assign flow_dma_active         = st_ff.dma_use;
   assign dma_tx_channel          = st_ff.dma_tx;
   assign status_fifo_interrupt   = st_ff.fsf_irq;
   assign auto_frame_split        = st_ff.auto_split;
   assign full_duplex_select      = st_ff.full_dx;
   assign rx_write_allow          = st_ff.rx_allow;
   assign handshake_status_reg    = st_ff.hs_view;
   assign rx_data_in              = st_ff.rx_in;

   property p_div_reload;
      @(posedge clock) disable iff (!rst_n)
      (mode_to_sir && st_ff.fc_mode[0] && st_ff.fc_mode[1])
         |=> (advanced_divisor_load && advanced_divisor == {$past(st_ff.div_hi), $past(st_ff.div_lo)});
   endproperty
   a_div_reload: assert property (p_div_reload) else $error("divisor not reloaded on SIR switch");

   property p_no_reload;
      @(posedge clock) disable iff (!rst_n)
      (!(mode_to_sir && st_ff.fc_mode[0] && st_ff.fc_mode[1])) |=> !advanced_divisor_load;
   endproperty
   a_no_reload: assert property (p_no_reload) else $error("divisor reloaded without enable");

   property p_mode_copy;
      @(posedge clock) disable iff (!rst_n)
      (mode_to_sir && st_ff.fc_mode[0])
         |=> (advanced_mode_load && advanced_handshake_mode == $past(st_ff.fc_mode[7:5]));
   endproperty
   a_mode_copy: assert property (p_mode_copy) else $error("handshake mode not copied");

   property p_gate;
      @(posedge clock) disable iff (!rst_n)
      !st_ff.fc_mode[0] |=> (!flow_dma_active && !dma_tx_channel);
   endproperty
   a_gate: assert property (p_gate) else $error("flow bits active while flow control off");

   property p_set_read;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h3) |=> (reg_rdata == 8'hec) ##1 (reg_rdata == 8'h00 || $past(reg_rd));
   endproperty
   a_set_read: assert property (p_set_read) else $error("set select read value wrong");

   property p_thresh;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> (status_fifo_interrupt == ($past(st_ff.count) >= ($past(st_ff.cfg[6]) ? 4'h4 : 4'h2)));
   endproperty
   a_thresh: assert property (p_thresh) else $error("status interrupt level wrong");

   property p_hs_disable;
      @(posedge clock) disable iff (!rst_n)
      st_ff.cfg[1] |=> (handshake_status_reg == 8'h30);
   endproperty
   a_hs_disable: assert property (p_hs_disable) else $error("handshake status not forced");

   property p_ready_read;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h5) |=> (reg_rdata[7] == ($past(st_ff.count) != 4'h0));
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("ready flag wrong");

   property p_stat_ovf;
      @(posedge clock) disable iff (!rst_n)
      (status_push && st_ff.count == 4'h8 && !pop) |=> (st_ff.stat_ovf && st_ff.count == 4'h8 && $stable(st_ff.mem));
   endproperty
   a_stat_ovf: assert property (p_stat_ovf) else $error("full status FIFO overrun mishandled");

   property p_pop;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h7 && st_ff.count != 4'h0 && !status_push) |=> (st_ff.count == $past(st_ff.count) - 4'h1);
   endproperty
   a_pop: assert property (p_pop) else $error("high length read did not pop");

   property p_lost_read;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h6 && st_ff.lost_flag) |=> (reg_rdata == $past(st_ff.lost_cnt));
   endproperty
   a_lost_read: assert property (p_lost_read) else $error("lost count not shown");

   property p_rx_stop;
      @(posedge clock) disable iff (!rst_n)
      (length_exceeded && !frame_start) |=> !rx_write_allow;
   endproperty
   a_rx_stop: assert property (p_rx_stop) else $error("receive writes not stopped");

   // Stop is checked one cycle at a time, so no unbounded wait is needed
   property p_rx_hold;
      @(posedge clock) disable iff (!rst_n)
      (!rx_write_allow && !frame_start) |=> !rx_write_allow;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive writes resumed early");

   property p_rx_resume;
      @(posedge clock) disable iff (!rst_n)
      frame_start |=> rx_write_allow;
   endproperty
   a_rx_resume: assert property (p_rx_resume) else $error("receive writes not resumed at start flag");

   property p_aux_sel;
      @(posedge clock) disable iff (!rst_n)
      st_ff.cfg[4] |=> (rx_data_in == $past(st_ff.pin_filt));
   endproperty
   a_aux_sel: assert property (p_aux_sel) else $error("receive input not from IR pin");

   property p_alt_sel;
      @(posedge clock) disable iff (!rst_n)
      !st_ff.cfg[4] |=> (rx_data_in == $past(st_ff.alt_filt));
   endproperty
   a_alt_sel: assert property (p_alt_sel) else $error("receive input not from normal pin");

   property p_dma_use;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> (flow_dma_active == ($past(st_ff.fc_mode[0]) && $past(st_ff.fc_mode[2])));
   endproperty
   a_dma_use: assert property (p_dma_use) else $error("flow DMA use wrong");

   property p_dma_dir;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> (dma_tx_channel == ($past(st_ff.fc_mode[0]) && $past(st_ff.fc_mode[3])));
   endproperty
   a_dma_dir: assert property (p_dma_dir) else $error("flow DMA direction wrong");

   property p_split;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> (auto_frame_split == $past(st_ff.cfg[5]));
   endproperty
   a_split: assert property (p_split) else $error("frame split select wrong");

   property p_duplex;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> (full_duplex_select == $past(st_ff.cfg[0]));
   endproperty
   a_duplex: assert property (p_duplex) else $error("duplex select wrong");

   property p_hs_live;
      @(posedge clock) disable iff (!rst_n)
      !st_ff.cfg[1] |=> (handshake_status_reg == $past(hs_status_in));
   endproperty
   a_hs_live: assert property (p_hs_live) else $error("handshake status not passed through");

   property p_bottom_read;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h5 && st_ff.count != 4'h0) |=> (reg_rdata[4:2] == $past({bottom.lex, bottom.phy, bottom.crc}));
   endproperty
   a_bottom_read: assert property (p_bottom_read) else $error("bottom entry flags wrong");

   property p_empty_read;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == 3'h5 && st_ff.count == 4'h0) |=> (!reg_rdata[7] && reg_rdata[4:2] == 3'h0);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("entry flags shown while empty");

   property p_rx_ovf;
      @(posedge clock) disable iff (!rst_n)
      rx_fifo_overrun |=> st_ff.rx_ovf;
   endproperty
   a_rx_ovf: assert property (p_rx_ovf) else $error("receive overrun flag not set");

endmodule
